// ---- src/carrier_gen_pkg.sv ----
package carrier_gen_pkg;

  // ==========================================================================
  // register port
  localparam int          ADDR_W             = 5;
  localparam int          DATA_W             = 16;
  localparam logic [4:0]  PATTERN_LEN_ADDR   = 5'h19;
  localparam logic [4:0]  PATTERN_LOAD_ADDR  = 5'h1a;
  localparam logic [4:0]  DIV_CTRL_ADDR      = 5'h1b;

  // ==========================================================================
  // generator geometry
  localparam int          PATTERN_WORD       = 16;
  localparam int          LEN_W              = 10;
  localparam int          SR_W               = 1024;
  localparam int          MODULES            = 4;

  // ==========================================================================
  // divider control field positions
  localparam int          HIGH_DRIVE_POS     = 12;
  localparam int          GATE_POS           = 11;
  localparam int          GEN_ON_POS         = 10;
  localparam int          CAL_POS            = 9;
  localparam int          CHAN_LSB           = 7;
  localparam int          MOD_DIV_LSB        = 4;
  localparam int          GEN_DIV_LSB        = 0;
  localparam int          LEN_LSB            = 0;

  // ==========================================================================
  // reset values
  localparam logic [11:0] DIV_CTRL_RESET     = 12'h000;
  localparam logic [9:0]  PATTERN_LEN_RESET  = 10'h000;
  localparam logic [15:0] READ_ZERO          = 16'h0000;

  typedef struct packed {
    logic       high_drive_select;
    logic       global_filter_gate;
    logic       generator_on;
    logic [1:0] cal_channel_select;
    logic [2:0] modulator_clk_div;
    logic [3:0] generator_clk_div;
  } div_ctrl_s;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b01,
    CAL_RUN  = 2'b10
  } cal_state_e;

endpackage : carrier_gen_pkg

// ---- src/carrier_generator_clock_setup.sv ----
`timescale 1ns/100ps
`default_nettype none

// Contract
// - pattern write shifts register up sixteen
// - pattern port reads back all zero
// - divider bits 15 to 13 read zero
// - bit 12 selects high drive outputs
// - sinc runs when gate and enable set
// - bit 10 switches generator on/off
// - writing one to bit 9 starts calibration
// - bit 9 reads calibration in progress
// - bits 8-7 pick calibration module
// - bits 6-4 divide modulator clock n+1
// - bits 3-0 divide generator clock n+1
// - pattern length sets active register bits
module carrier_generator_clock_setup
  import carrier_gen_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output var  logic [DATA_W-1:0] reg_rdata,
  input  wire logic [MODULES-1:0] per_module_filter_on,
  input  wire logic              phase_cal_done,
  output var  logic              carrier_out_a,
  output var  logic              carrier_out_b,
  output var  logic              high_drive_select,
  output var  logic [MODULES-1:0] sinc_run,
  output var  logic              modulator_clk_tick,
  output var  logic              phase_cal_start,
  output var  logic [1:0]        cal_module,
  output var  logic              phase_cal_busy
);

  // ==========================================================================
  // helpers
  // divider terminal count: code 0 hits every cycle, code n every n+1
  function automatic logic div_hit(input logic [3:0] cnt,
                                   input logic [3:0] code);
    div_hit = (cnt >= code);
  endfunction

  // exact match of the register address, shared by write and read decode
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] target);
    addr_hit = (addr == target);
  endfunction

  // ==========================================================================
  // state
  div_ctrl_s        ctrl;
  logic [LEN_W-1:0] pattern_length;
  logic [SR_W-1:0]  shift_pattern_bits;
  logic [LEN_W-1:0] bit_ptr;
  logic [3:0]       gen_cnt;
  logic [2:0]       mod_cnt;
  cal_state_e       cal_state;
  cal_state_e       next_cal_state;

  // ==========================================================================
  // address decode
  wire logic sel_len = addr_hit(reg_addr, PATTERN_LEN_ADDR);
  wire logic sel_pat = addr_hit(reg_addr, PATTERN_LOAD_ADDR);
  wire logic sel_div = addr_hit(reg_addr, DIV_CTRL_ADDR);

  wire logic wr_len  = reg_wr && sel_len;
  wire logic wr_pat  = reg_wr && sel_pat;
  wire logic wr_div  = reg_wr && sel_div;
  wire logic cal_req = wr_div && reg_wdata[CAL_POS];

  wire div_ctrl_s next_ctrl = '{
    high_drive_select:  reg_wdata[HIGH_DRIVE_POS],
    global_filter_gate: reg_wdata[GATE_POS],
    generator_on:       reg_wdata[GEN_ON_POS],
    cal_channel_select: reg_wdata[CHAN_LSB+:2],
    modulator_clk_div:  reg_wdata[MOD_DIV_LSB+:3],
    generator_clk_div:  reg_wdata[GEN_DIV_LSB+:4]
  };

  wire logic [LEN_W-1:0] next_pattern_length = reg_wdata[LEN_LSB+:LEN_W];

  // new word enters at the bottom, the oldest word falls off the top
  wire logic [SR_W-1:0] next_shift_pattern =
    {shift_pattern_bits[SR_W-PATTERN_WORD-1:0], reg_wdata};

  // ==========================================================================
  // divider hits and pattern pointer
  wire logic gen_hit = div_hit(gen_cnt, ctrl.generator_clk_div);
  wire logic mod_hit = div_hit({1'b0, mod_cnt},
                               {1'b0, ctrl.modulator_clk_div});
  wire logic gen_tick = ctrl.generator_on && gen_hit;

  // the generator counter rests at zero while the generator is off
  wire logic [3:0] next_gen_cnt =
    (!ctrl.generator_on || gen_hit) ? 4'h0 : gen_cnt + 4'h1;
  wire logic [2:0] next_mod_cnt = mod_hit ? 3'h0 : mod_cnt + 3'h1;

  // pointer walks from pattern_length down to 0, then wraps
  wire logic [LEN_W-1:0] next_bit_ptr =
    !ctrl.generator_on  ? pattern_length :
    !gen_tick           ? bit_ptr :
    (bit_ptr == '0)     ? pattern_length : bit_ptr - 10'h001;

  // ==========================================================================
  // carrier bit selection
  // pattern bit under the pointer, both outputs quiet while off
  wire logic pattern_bit    = shift_pattern_bits[bit_ptr];
  wire logic next_carrier_a = ctrl.generator_on & pattern_bit;
  wire logic next_carrier_b = ctrl.generator_on & ~pattern_bit;

  // ==========================================================================
  // read mux
  wire logic cal_running = (cal_state == CAL_RUN);

  // bits 15..13 and the status bit assembled around the stored fields
  wire logic [DATA_W-1:0] div_rd = {3'b000,
                                    ctrl.high_drive_select,
                                    ctrl.global_filter_gate,
                                    ctrl.generator_on,
                                    cal_running,
                                    ctrl.cal_channel_select,
                                    ctrl.modulator_clk_div,
                                    ctrl.generator_clk_div};

  wire logic [DATA_W-1:0] len_rd = {6'b000000, pattern_length};

  wire logic [DATA_W-1:0] rd_mux =
    sel_div ? div_rd :
    sel_len ? len_rd :
    READ_ZERO;
  wire logic [DATA_W-1:0] next_rdata = reg_rd ? rd_mux : READ_ZERO;

  // ==========================================================================
  // register writes
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= DIV_CTRL_RESET;
    end else if (wr_div) begin
      ctrl <= next_ctrl;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pattern_length <= PATTERN_LEN_RESET;
    end else if (wr_len) begin
      pattern_length <= next_pattern_length;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_pattern_bits <= '0;
    end else if (wr_pat) begin
      shift_pattern_bits <= next_shift_pattern;
    end
  end

  // ==========================================================================
  // read port, data in the cycle after the strobe only
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= READ_ZERO;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // ==========================================================================
  // divider counters
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      gen_cnt <= 4'h0;
    end else begin
      gen_cnt <= next_gen_cnt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mod_cnt <= 3'h0;
    end else begin
      mod_cnt <= next_mod_cnt;
    end
  end

  // modulator clock enable, one pulse per divided period
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      modulator_clk_tick <= 1'b0;
    end else begin
      modulator_clk_tick <= mod_hit;
    end
  end

  // ==========================================================================
  // pattern walk and carrier outputs
  // pointer reloads the length whenever the generator is off
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_ptr <= PATTERN_LEN_RESET;
    end else begin
      bit_ptr <= next_bit_ptr;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      carrier_out_a <= 1'b0;
    end else begin
      carrier_out_a <= next_carrier_a;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      carrier_out_b <= 1'b0;
    end else begin
      carrier_out_b <= next_carrier_b;
    end
  end

  // ==========================================================================
  // drive strength select, shared by both carrier outputs
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      high_drive_select <= 1'b0;
    end else begin
      high_drive_select <= ctrl.high_drive_select;
    end
  end

  // ==========================================================================
  // sinc filter gating per module
  for (genvar m = 0; m < MODULES; m++) begin : g_sinc
    // gate and the module's own enable must both be set
    wire logic run_req = ctrl.global_filter_gate & per_module_filter_on[m];
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        sinc_run[m] <= 1'b0;
      end else begin
        sinc_run[m] <= run_req;
      end
    end
  end

  // ==========================================================================
  // phase calibration sequencing; a new start wins over a finish
  always_comb begin
    next_cal_state = cal_state;
    case (cal_state)
      CAL_IDLE: begin
        if (cal_req) begin
          next_cal_state = CAL_RUN;
        end
      end
      CAL_RUN: begin
        if (phase_cal_done && !cal_req) begin
          next_cal_state = CAL_IDLE;
        end
      end
      default: begin
        next_cal_state = CAL_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cal_state      <= CAL_IDLE;
      phase_cal_busy <= 1'b0;
    end else begin
      cal_state      <= next_cal_state;
      phase_cal_busy <= (next_cal_state == CAL_RUN);
    end
  end

  // one start pulse per write of the trigger bit
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_cal_start <= 1'b0;
    end else begin
      phase_cal_start <= cal_req;
    end
  end

  // module under calibration, latched at each start
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cal_module <= 2'b00;
    end else if (cal_req) begin
      cal_module <= reg_wdata[CHAN_LSB+:2];
    end
  end

endmodule // carrier_generator_clock_setup

`default_nettype wire

// ---- test/carrier_generator_clock_setup_props.sv ----
`timescale 1ns/100ps
`default_nettype none
module carrier_generator_clock_setup_props
  import carrier_gen_pkg::*;
(
  input wire logic               core_clk,
  input wire logic               rst_b,
  input wire logic [ADDR_W-1:0]  reg_addr,
  input wire logic [DATA_W-1:0]  reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [DATA_W-1:0]  reg_rdata,
  input wire logic [MODULES-1:0] per_module_filter_on,
  input wire logic               phase_cal_done,
  input wire logic               carrier_out_a,
  input wire logic               carrier_out_b,
  input wire logic               high_drive_select,
  input wire logic [MODULES-1:0] sinc_run,
  input wire logic               phase_cal_start,
  input wire logic [1:0]         cal_module,
  input wire logic               phase_cal_busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wire dwr = reg_wr && reg_addr == DIV_CTRL_ADDR;
  wire drd = reg_rd && reg_addr == DIV_CTRL_ADDR;
  wire cal_wr = dwr && reg_wdata[CAL_POS];
  wire logic       wdata_drive = reg_wdata[HIGH_DRIVE_POS];
  wire logic [1:0] wdata_chan  = reg_wdata[CHAN_LSB+:2];
  // ==========================================================================
  // properties
  property p_load_rd;
    reg_rd && reg_addr == PATTERN_LOAD_ADDR |=> reg_rdata == 16'h0000; endproperty
  a_load_rd: assert property (p_load_rd) else $error("pattern read");
  property p_top_zero;
    drd |=> reg_rdata[15:13] == 3'b000; endproperty
  a_top_zero: assert property (p_top_zero) else $error("top bits");
  property p_drive;
    dwr |-> ##2 high_drive_select == $past(wdata_drive, 2); endproperty
  a_drive: assert property (p_drive) else $error("drive mode");
  property p_gate_off;
    dwr && !reg_wdata[GATE_POS] |-> ##2 sinc_run == 4'h0; endproperty
  a_gate_off: assert property (p_gate_off) else $error("gate off");
  property p_gate_and;
    (sinc_run & ~$past(per_module_filter_on)) == 4'h0; endproperty
  a_gate_and: assert property (p_gate_and) else $error("filter and");
  property p_gen_off;
    dwr && !reg_wdata[GEN_ON_POS] |-> ##2 !carrier_out_a && !carrier_out_b;
  endproperty
  a_gen_off: assert property (p_gen_off) else $error("gen off");
  property p_cal_start;
    cal_wr |=> phase_cal_start && phase_cal_busy &&
      cal_module == $past(wdata_chan); endproperty
  a_cal_start: assert property (p_cal_start)
    else $error("cal start");
  property p_cal_end;
    phase_cal_busy && phase_cal_done && !cal_wr |=> !phase_cal_busy;
  endproperty
  a_cal_end: assert property (p_cal_end) else $error("cal end");
endmodule // carrier_generator_clock_setup_props
bind carrier_generator_clock_setup
  carrier_generator_clock_setup_props u_props (
  .core_clk             (core_clk),
  .rst_b                (rst_b),
  .reg_addr             (reg_addr),
  .reg_wdata            (reg_wdata),
  .reg_wr               (reg_wr),
  .reg_rd               (reg_rd),
  .reg_rdata            (reg_rdata),
  .per_module_filter_on (per_module_filter_on),
  .phase_cal_done       (phase_cal_done),
  .carrier_out_a        (carrier_out_a),
  .carrier_out_b        (carrier_out_b),
  .high_drive_select    (high_drive_select),
  .sinc_run             (sinc_run),
  .phase_cal_start      (phase_cal_start),
  .cal_module           (cal_module),
  .phase_cal_busy       (phase_cal_busy)
);
`default_nettype wire

// ---- test/carrier_generator_clock_setup_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module carrier_generator_clock_setup_test;
  import carrier_gen_pkg::*;
  logic core_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, phase_cal_done = 0;
  logic [4:0] reg_addr = 0;
  logic [15:0] reg_wdata = 0;
  logic [3:0] per_module_filter_on = 0;
  wire logic [15:0] reg_rdata;
  wire logic carrier_out_a, carrier_out_b, high_drive_select;
  wire logic modulator_clk_tick, phase_cal_start, phase_cal_busy;
  wire logic [3:0] sinc_run;
  wire logic [1:0] cal_module;
  int fail_count = 0, cmp_count = 0, cyc = 0;
  carrier_generator_clock_setup dut (
    .core_clk             (core_clk),
    .rst_b                (rst_b),
    .reg_addr             (reg_addr),
    .reg_wdata            (reg_wdata),
    .reg_wr               (reg_wr),
    .reg_rd               (reg_rd),
    .reg_rdata            (reg_rdata),
    .per_module_filter_on (per_module_filter_on),
    .phase_cal_done       (phase_cal_done),
    .carrier_out_a        (carrier_out_a),
    .carrier_out_b        (carrier_out_b),
    .high_drive_select    (high_drive_select),
    .sinc_run             (sinc_run),
    .modulator_clk_tick   (modulator_clk_tick),
    .phase_cal_start      (phase_cal_start),
    .cal_module           (cal_module),
    .phase_cal_busy       (phase_cal_busy)
  );
  initial forever #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      final_report();
    end
  end
  // ==========================================================================
  // helpers
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e, input string n);
    @(posedge core_clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 0;
    #1 chk(n, e, reg_rdata);
  endtask
  // cycles between two rising edges of the chosen output
  task automatic gap(input bit s, input int e, input string n);
    logic p, c;
    int f, g;
    p = 1;
    f = -1;
    g = 0;
    for (int i = 0; i < 100 && g == 0; i++) begin
      @(posedge core_clk);
      #1 c = s ? carrier_out_a : modulator_clk_tick;
      if (c && !p) begin
        if (f >= 0) g = i - f;
        f = i;
      end
      p = c;
    end
    chk(n, e[15:0], g[15:0]);
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ==========================================================================
  // scenarios
  initial begin
    logic [31:0] pat;
    repeat (12) @(posedge core_clk);
    rst_b <= 1;
    rd(DIV_CTRL_ADDR, 16'h0000, "div reset");
    wr(DIV_CTRL_ADDR, 16'hfdff);
    rd(DIV_CTRL_ADDR, 16'h1dff, "div readback");
    chk("high drive", 16'h0001, {15'h0000, high_drive_select});
    wr(PATTERN_LEN_ADDR, 16'hffff);
    rd(PATTERN_LEN_ADDR, 16'h03ff, "length");
    wr(PATTERN_LOAD_ADDR, 16'hffff);
    rd(PATTERN_LOAD_ADDR, 16'h0000, "pattern read");
    rd(5'h05, 16'h0000, "unmapped");
    $display("test registers done");
    per_module_filter_on <= 4'b1011;
    for (int g = 0; g < 2; g++) begin
      wr(DIV_CTRL_ADDR, g ? 16'h0800 : 16'h0000);
      repeat (3) @(posedge core_clk);
      chk("sinc run", g ? 16'h000b : 16'h0000, {12'h000, sinc_run});
    end
    $display("test sinc gate done");
    for (int ch = 0; ch < 4; ch++) begin
      wr(DIV_CTRL_ADDR, 16'h0200 | 16'(ch << 7));
      #1 chk("cal start", 16'h0001, {15'h0000, phase_cal_start});
      chk("cal module", 16'(ch), {14'h0000, cal_module});
      rd(DIV_CTRL_ADDR, 16'h0200 | 16'(ch << 7), "cal busy");
      @(posedge core_clk);
      phase_cal_done <= 1;
      @(posedge core_clk);
      phase_cal_done <= 0;
      rd(DIV_CTRL_ADDR, 16'(ch << 7), "cal idle");
    end
    $display("test calibration done");
    pat = 32'h1234_a5c3;
    wr(PATTERN_LEN_ADDR, 16'h001f);
    wr(PATTERN_LOAD_ADDR, pat[31:16]);
    wr(PATTERN_LOAD_ADDR, pat[15:0]);
    wr(DIV_CTRL_ADDR, 16'h1400);
    for (int i = 31; i >= 0; i--) begin
      @(posedge core_clk);
      #1 chk("out a", {15'h0000, pat[i]}, {15'h0000, carrier_out_a});
      chk("out b", {15'h0000, !pat[i]}, {15'h0000, carrier_out_b});
    end
    wr(DIV_CTRL_ADDR, 16'h0000);
    repeat (2) @(posedge core_clk);
    #1 chk("gen off", 16'h0000, {14'h0000, carrier_out_a, carrier_out_b});
    $display("test pattern done");
    wr(PATTERN_LEN_ADDR, 16'h0001);
    wr(PATTERN_LOAD_ADDR, 16'h0002);
    for (int n = 0; n < 16; n++) begin
      wr(DIV_CTRL_ADDR, 16'h0400 | 16'((n % 8) << 4) | 16'(n));
      gap(1, 2 * (n + 1), "gen period");
      if (n % 8 == 0) begin
        chk("mod tick", 16'h0001, {15'h0000, modulator_clk_tick});
      end else begin
        gap(0, n % 8 + 1, "mod period");
      end
    end
    $display("test dividers done");
    final_report();
  end
endmodule // carrier_generator_clock_setup_test
`default_nettype wire
